/* sleep_sub_pkg.sv */
// Package for the sleep / literal-subtract execution block.
// Assumes a 14-bit instruction word and an 8-bit accumulator datapath.
package sleep_sub_pkg;
	localparam int unsigned INSTR_W = 14;
	localparam int unsigned DATA_W  = 8;
	// Fixed low-power entry pattern
	localparam logic [13:0] SLEEP_PATTERN = 14'h0063;
	// Upper bits of literal-subtract, bit 8 ignored
	localparam logic [4:0]  LIT_SUB_HI    = 5'h1E;
	localparam logic [7:0]  WDOG_CLEAR    = 8'h00;
	localparam logic [7:0]  ACC_RESET     = 8'h00;
	localparam logic [1:0]  PHASE_RESET   = 2'h0;
	// Both power flags read high out of reset
	localparam logic [1:0]  PWR_RESET     = 2'h3;

	// Q phase of the instruction cycle
	typedef enum logic [1:0] {Q1, Q2, Q3, Q4} qphase_t;

	// Flags written back by the block
	typedef struct packed {
		logic carry;
		logic digit_carry;
		logic zero;
	} alu_flags_t;

	// Power status flags
	typedef struct packed {
		logic timeout_flag;
		logic powerdown_flag;
	} power_flags_t;
endpackage : sleep_sub_pkg

/* phase_gen.sv */
// Q1..Q4 phase sequencer for the instruction cycle.
// Assumes ref_clk is the phase clock; phases advance while run is high.
`timescale 1ns/1ps
`default_nettype none
module phase_gen (
	input  wire logic                 ref_clk,
	input  wire logic                 rst_n,
	input  wire logic                 run,
	output sleep_sub_pkg::qphase_t    phase
);
	sleep_sub_pkg::qphase_t phase_r;
	sleep_sub_pkg::qphase_t phase_nxt;

	// Step through the four phases, hold at Q1 while halted
	always_comb begin
		phase_nxt = phase_r;
		if (!run) begin
			phase_nxt = sleep_sub_pkg::Q1;
		end else begin
			phase_nxt = sleep_sub_pkg::qphase_t'(phase_r + 2'h1);
		end
	end

	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			phase_r <= sleep_sub_pkg::Q1;
		end else begin
			phase_r <= phase_nxt;
		end
	end

	assign phase = phase_r;
endmodule : phase_gen
`default_nettype wire

/* sleep_sub_exec.sv */
// Execution of the low-power entry and literal-minus-accumulator instructions.
// Assumes instr is stable from Q1 to Q4 and comes from same-clock fetch logic.
// Assumes acc_in is the datapath accumulator on the same clock, updated on the edge after acc_we.
// Assumes wake comes from same-clock wake logic, so it is read without a synchroniser.
// One ref_clk cycle is one Q phase; four cycles make one instruction cycle.
// Only the two instructions above are decoded; every other word passes as an idle cycle.
// The sleep entry holds until wake; no instruction is taken while asleep.
// Outputs:
//   acc_out, flags_out     result and carry, digit carry, zero of the last subtract
//   acc_we                 one-cycle pulse while acc_out and flags_out are new
//   power_flags            timeout and powerdown status, both high out of reset
//   watchdog_counter_clr   one-cycle clear pulse to the watchdog counter
//   prescaler_clr          one-cycle clear pulse to the watchdog prescaler
//   osc_stop, core_halted  high from sleep entry until wake
//   q_phase                registered phase, one cycle behind the sequencer
//
// Contract
// - Low-power entry clears the watchdog counter to zero and clears its prescaler.
// - Low-power entry sets the timeout flag to one.
// - Low-power entry clears the powerdown flag to zero.
// - After low-power entry the core stops executing and stays asleep; the code leaves sleep when wake is high.
// - While asleep the main oscillator is held stopped.
// - Carry is one for zero or positive result, zero for negative; zero flag marks a zero result.
// - Literal subtract is one word, one cycle: decode Q1, read Q2, process Q3, write Q4.
`timescale 1ns/1ps
`default_nettype none
module sleep_sub_exec (
	// Clock and reset
	input  wire logic                        ref_clk,
	input  wire logic                        rst_n,
	// From fetch and wake logic
	input  wire logic [13:0]                 instr,
	input  wire logic                        wake,
	// Accumulator exchange with the datapath
	input  wire logic [7:0]                  acc_in,
	output logic [7:0]                       acc_out,
	output logic                             acc_we,
	output sleep_sub_pkg::alu_flags_t        flags_out,
	// Status, watchdog and clock control
	output sleep_sub_pkg::power_flags_t      power_flags,
	output logic                             watchdog_counter_clr,
	output logic                             prescaler_clr,
	output logic                             osc_stop,
	output logic                             core_halted,
	output logic [1:0]                       q_phase
);
	sleep_sub_pkg::qphase_t phase;
	// Sleep state
	logic                   asleep_r;
	logic                   asleep_nxt;
	// Decoded instruction
	logic                   is_sleep_r;
	logic                   is_sleep_nxt;
	logic                   is_sub_r;
	logic                   is_sub_nxt;
	// Operand and difference pipeline
	logic [7:0]             lit_r;
	logic [7:0]             lit_nxt;
	logic [8:0]             diff_r;
	logic [8:0]             diff_nxt;
	logic                   dc_r;
	logic                   dc_nxt;
	// Accumulator copy and registered outputs
	logic [7:0]             acc_r;
	logic [7:0]             acc_nxt;
	logic                   we_r;
	logic                   we_nxt;
	sleep_sub_pkg::alu_flags_t   flg_r;
	sleep_sub_pkg::alu_flags_t   flg_nxt;
	sleep_sub_pkg::power_flags_t pwr_r;
	sleep_sub_pkg::power_flags_t pwr_nxt;
	logic                   wdc_r;
	logic                   wdc_nxt;
	logic [1:0]             qo_r;
	logic [1:0]             qo_nxt;
	// Ripple chain for literal plus inverted accumulator plus one
	wire logic [8:0]        sum_carry;
	wire logic [7:0]        sum_bit;

	// The decode patterns and the adder chain are sized for these widths; refuse others early
	if (sleep_sub_pkg::INSTR_W != 14) begin : g_instr_w_check
		$error("sleep_sub_exec needs a 14-bit instruction word");
	end
	if (sleep_sub_pkg::DATA_W != 8) begin : g_data_w_check
		$error("sleep_sub_exec needs an 8-bit datapath");
	end

	// Phase sequencer; it parks at Q1 while the core sleeps
	phase_gen u_phase (
		.ref_clk (ref_clk),
		.rst_n   (rst_n),
		.run     (~asleep_r),
		.phase   (phase)
	);

	// Subtraction as a per-bit ripple chain: the carry into bit 4 is the nibble no-borrow
	// flag, so digit carry needs no second adder; the cost is an eight-stage carry path,
	// which one whole phase cycle easily covers
	assign sum_carry[0] = 1'b1;
	for (genvar b = 0; b < 8; b++) begin : g_sub_bit
		assign sum_bit[b]       = lit_r[b] ^ ~acc_r[b] ^ sum_carry[b];
		assign sum_carry[b + 1] = (lit_r[b] & ~acc_r[b]) | (sum_carry[b] & (lit_r[b] ^ ~acc_r[b]));
	end

	// Decode in Q1, latch literal in Q2, compute in Q3, write in Q4
	always_comb begin
		// Defaults: pulses drop, the phase copy follows phase, every other held value keeps its state
		is_sleep_nxt = is_sleep_r;
		is_sub_nxt   = is_sub_r;
		lit_nxt      = lit_r;
		diff_nxt     = diff_r;
		dc_nxt       = dc_r;
		acc_nxt      = acc_r;
		we_nxt       = 1'b0;
		flg_nxt      = flg_r;
		pwr_nxt      = pwr_r;
		wdc_nxt      = 1'b0;
		asleep_nxt   = asleep_r;
		qo_nxt       = 2'(phase);
		if (asleep_r) begin
			// Only a wake event ends the halt; no instruction runs meanwhile
			if (wake) begin
				asleep_nxt = 1'b0;
			end
		end else begin
			case (phase)
				sleep_sub_pkg::Q1: begin
					// Both matches come from one stable word; at most one can be true
					is_sleep_nxt = (instr == sleep_sub_pkg::SLEEP_PATTERN);
					is_sub_nxt   = (instr[13:9] == sleep_sub_pkg::LIT_SUB_HI);
				end
				sleep_sub_pkg::Q2: begin
					// The sleep pattern has nothing to read here
					if (is_sub_r) begin
						lit_nxt = instr[7:0];
					end
				end
				sleep_sub_pkg::Q3: begin
					if (is_sub_r) begin
						// Two's complement difference; the top bit is the no-borrow carry
						diff_nxt = {sum_carry[8], sum_bit};
						// No borrow out of the low nibble
						dc_nxt   = sum_carry[4];
					end
				end
				default: begin
					// Q4: write the difference back, or enter sleep
					if (is_sub_r) begin
						acc_nxt               = diff_r[7:0];
						we_nxt                = 1'b1;
						flg_nxt.carry         = diff_r[8];
						flg_nxt.digit_carry   = dc_r;
						flg_nxt.zero          = (diff_r[7:0] == 8'h00);
					end
					if (is_sleep_r) begin
						// Clears, flags and halt move on one edge, so no one sees a half-entered sleep
						wdc_nxt                  = 1'b1;
						pwr_nxt.timeout_flag     = 1'b1;
						pwr_nxt.powerdown_flag   = 1'b0;
						asleep_nxt               = 1'b1;
					end
				end
			endcase
		end
		// Copy the accumulator in at Q1 while awake, except right after our own write: the datapath
		// register takes that result on this same edge, so acc_in still holds the old value
		// and a back-to-back subtract would otherwise use a stale operand
		if (!we_r && !asleep_r && phase == sleep_sub_pkg::Q1) begin
			acc_nxt = acc_in;
		end
	end

	// State registers; reset leaves the core awake with both power flags high
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n) begin
			is_sleep_r <= 1'b0;
			is_sub_r   <= 1'b0;
			lit_r      <= sleep_sub_pkg::ACC_RESET;
			diff_r     <= 9'h000;
			dc_r       <= 1'b0;
			acc_r      <= sleep_sub_pkg::ACC_RESET;
			we_r       <= 1'b0;
			flg_r      <= '0;
			pwr_r      <= sleep_sub_pkg::PWR_RESET;
			wdc_r      <= 1'b0;
			asleep_r   <= 1'b0;
			qo_r       <= sleep_sub_pkg::PHASE_RESET;
		end else begin
			is_sleep_r <= is_sleep_nxt;
			is_sub_r   <= is_sub_nxt;
			lit_r      <= lit_nxt;
			diff_r     <= diff_nxt;
			dc_r       <= dc_nxt;
			acc_r      <= acc_nxt;
			we_r       <= we_nxt;
			flg_r      <= flg_nxt;
			pwr_r      <= pwr_nxt;
			wdc_r      <= wdc_nxt;
			asleep_r   <= asleep_nxt;
			qo_r       <= qo_nxt;
		end
	end

	// All outputs straight from flops
	// Result, flags and strobe leave together, so the datapath never sees a torn update
	assign acc_out              = acc_r;
	assign acc_we               = we_r;
	assign flags_out            = flg_r;
	assign power_flags          = pwr_r;
	// Both clears share one pulse: the prescaler never outlives the counter it feeds
	assign watchdog_counter_clr = wdc_r;
	assign prescaler_clr        = wdc_r;
	// Halt and oscillator stop are one level, so the clock never runs without the core
	assign osc_stop             = asleep_r;
	assign core_halted          = asleep_r;
	// Phase copy lags the sequencer by one cycle, registered like every other output
	assign q_phase              = qo_r;
endmodule : sleep_sub_exec
`default_nettype wire

/* sleep_sub_asserts.sv */
// Port checker for the sleep / literal-subtract block.
// Assumes it is bound onto sleep_sub_exec and watches only its ports.
`timescale 1ns/1ps
`default_nettype none
module sleep_sub_asserts (
	input wire logic                        ref_clk,
	input wire logic                        rst_n,
	input wire logic                        wake,
	input wire logic [7:0]                  acc_out,
	input wire logic                        acc_we,
	input wire sleep_sub_pkg::alu_flags_t   flags_out,
	input wire sleep_sub_pkg::power_flags_t power_flags,
	input wire logic                        watchdog_counter_clr,
	input wire logic                        prescaler_clr,
	input wire logic                        osc_stop,
	input wire logic                        core_halted
);
	default clocking @(posedge ref_clk); endclocking
	default disable iff (!rst_n);
	// Sleep entry is one step: both clears pulse as the halt begins
	sequence s_enter;
		watchdog_counter_clr && prescaler_clr;
	endsequence
	property p_clr; s_enter |-> $rose(core_halted) ##1 !watchdog_counter_clr; endproperty
	a_clr: assert property (p_clr) else $error("clear pulse wrong");
	property p_to; $rose(core_halted) |-> power_flags.timeout_flag; endproperty
	a_to: assert property (p_to) else $error("timeout flag not set");
	property p_pd; $rose(core_halted) |-> !power_flags.powerdown_flag; endproperty
	a_pd: assert property (p_pd) else $error("powerdown flag not clear");
	property p_halt; core_halted && !wake |=> core_halted; endproperty
	a_halt: assert property (p_halt) else $error("left sleep without wake");
	property p_nox; core_halted |-> !acc_we; endproperty
	a_nox: assert property (p_nox) else $error("write while asleep");
	property p_osc; core_halted |-> osc_stop; endproperty
	a_osc: assert property (p_osc) else $error("oscillator running asleep");
	property p_zero; acc_we |-> flags_out.zero == (acc_out == 8'h00); endproperty
	a_zero: assert property (p_zero) else $error("zero flag wrong");
	// At most one write per four-phase cycle
	property p_we; acc_we |=> !acc_we [*3]; endproperty
	a_we: assert property (p_we) else $error("write too soon");
endmodule : sleep_sub_asserts
bind sleep_sub_exec sleep_sub_asserts u_chk (.ref_clk, .rst_n, .wake, .acc_out, .acc_we, .flags_out,
	.power_flags, .watchdog_counter_clr, .prescaler_clr, .osc_stop, .core_halted);
`default_nettype wire

/* acc_model.sv */
// Accumulator register of the core datapath, far side of the block.
// Assumes writes arrive as one-cycle acc_we pulses.
`timescale 1ns/1ps
`default_nettype none
module acc_model (
	input  wire logic       ref_clk,
	input  wire logic       rst_n,
	input  wire logic       acc_we,
	input  wire logic [7:0] acc_out,
	output logic [7:0]      acc_in
);
	// Holds its value between writes, as the real register does
	always_ff @(posedge ref_clk or negedge rst_n) begin
		if (!rst_n)
			acc_in <= sleep_sub_pkg::ACC_RESET;
		else if (acc_we)
			acc_in <= acc_out;
	end
endmodule : acc_model
`default_nettype wire

/* testbench.sv */
// Self-checking bench for sleep_sub_exec with an accumulator model.
// Assumes phase Q1 falls on the first edge after reset release.
`timescale 1ns/1ps
`default_nettype none
module testbench;
	logic                        ref_clk = 1'b0;
	logic                        rst_n = 1'b0;
	logic                        wake = 1'b0;
	logic [13:0]                 instr = 14'h0000;
	logic [7:0]                  w_exp = 8'h00;
	logic [7:0]                  acc_in, acc_out;
	logic                        acc_we, wd_clr, ps_clr, osc_stop, core_halted;
	logic [1:0]                  q_phase;
	sleep_sub_pkg::alu_flags_t   flags_out;
	sleep_sub_pkg::power_flags_t power_flags;
	int                          n_errors = 0;
	int                          checks = 0;
	always #12.5 ref_clk = ~ref_clk;
	sleep_sub_exec u_dut (.ref_clk, .rst_n, .instr, .wake, .acc_in, .acc_out, .acc_we, .flags_out,
		.power_flags, .watchdog_counter_clr(wd_clr), .prescaler_clr(ps_clr), .osc_stop, .core_halted, .q_phase);
	acc_model u_acc (.ref_clk, .rst_n, .acc_we, .acc_out, .acc_in);
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			n_errors++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask : chk
	// Word held over Q1..Q4; returns at the falling edge after Q4, while one-cycle results stand
	task automatic issue(input logic [13:0] word);
		instr = word;
		repeat (4) @(negedge ref_clk);
	endtask : issue
	// Positive, zero and negative results back to back, one idle cycle after the third; ignored bit toggled
	task automatic sub_table();
		logic [7:0] lits [6] = '{8'h01, 8'h03, 8'h02, 8'h01, 8'h00, 8'hFF};
		logic [7:0] r;
		for (int i = 0; i < 6; i++) begin
			r = lits[i] - w_exp;
			issue({sleep_sub_pkg::LIT_SUB_HI, i[0], lits[i]});
			chk("we", 8'h01, {7'h00, acc_we});
			chk("q_phase", 8'h03, {6'h00, q_phase});
			chk("acc", r, acc_out);
			chk("flags", {5'h00, lits[i] >= w_exp, lits[i][3:0] >= w_exp[3:0], r == 8'h00}, {5'h00, flags_out});
			w_exp = r;
			if (i == 2) begin
				issue(14'h0000);
				chk("idle we", 8'h00, {7'h00, acc_we});
			end
		end
	endtask : sub_table
	// Sleep entry, words ignored while halted, then wake and resume
	task automatic sleep_wake();
		issue(sleep_sub_pkg::SLEEP_PATTERN);
		chk("clears", 8'h03, {6'h00, wd_clr, ps_clr});
		chk("power", 8'h02, {6'h00, power_flags});
		instr = {sleep_sub_pkg::LIT_SUB_HI, 1'b0, 8'h55};
		repeat (12) @(negedge ref_clk);
		chk("asleep", 8'h03, {6'h00, core_halted, osc_stop});
		chk("parked phase", 8'h00, {6'h00, q_phase});
		chk("held acc", w_exp, acc_out);
		instr = 14'h0000;
		wake = 1'b1;
		@(negedge ref_clk);
		chk("awake", 8'h00, {7'h00, core_halted});
		wake = 1'b0;
		issue({sleep_sub_pkg::LIT_SUB_HI, 1'b1, 8'h10});
		chk("resumed", 8'h10 - w_exp, acc_out);
		chk("resumed we", 8'h01, {7'h00, acc_we});
		chk("resumed flags", 8'h06, {5'h00, flags_out});
	endtask : sleep_wake
	task automatic summarize();
		$display("checks %0d n_errors %0d", checks, n_errors);
		if (n_errors == 0 && checks > 0)
			$display("[ PASS ]");
		else
			$display("[ FAIL ]");
		$finish;
	endtask : summarize
	initial begin
		repeat (4) @(negedge ref_clk);
		chk("reset power", 8'h03, {6'h00, power_flags});
		rst_n = 1'b1;
		sub_table();
		sleep_wake();
		summarize();
	end
	// Run needs under 100 cycles; 400 means a hang
	initial begin
		#(25 * 400);
		n_errors++;
		summarize();
	end
endmodule : testbench
`default_nettype wire
